// [test/dlc_i2c_ctrl.sv]
// Bus controller model driving the serial pins of the light converter.
// Assumes SDA is open drain with a pull-up resolved by the bench.
`timescale 1ns/100ps
module dlc_i2c_ctrl (
	output logic      scl,
	output logic      sdaRel,
	input  wire logic sdaLine
);
	// ---
	// Bit timing
	// ---
	localparam int QTR_NS = 625; // 2500 ns bits, 400 kbit/s

	initial begin
		scl = 1'b1;
		sdaRel = 1'b1;
	end

	// ---
	// Transfer tasks
	// ---
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#QTR_NS sdaRel = b[i]; // MSB first
			#QTR_NS scl = 1'b1;
			#(2*QTR_NS) scl = 1'b0;
		end
		#QTR_NS sdaRel = 1'b1;
		#QTR_NS scl = 1'b1;
		#QTR_NS ack = ~sdaLine;
		#QTR_NS scl = 1'b0;
	endtask

	// Clear command goes out as a write
	task automatic write_cmd(input logic [6:0] a, input logic [7:0] d, output logic ackA, output logic ackD);
		sdaRel = 1'b1;
		#QTR_NS sdaRel = 1'b0;
		#QTR_NS scl = 1'b0;
		send_byte({a, 1'b0}, ackA);
		ackD = 1'b0;
		if (ackA) begin
			send_byte(d, ackD);
		end
		#QTR_NS sdaRel = 1'b0;
		#QTR_NS scl = 1'b1;
		#QTR_NS sdaRel = 1'b1;
		#(4*QTR_NS);
	endtask

	// Address-only transfer, used for refused reads
	task automatic probe(input logic [7:0] first, output logic ack);
		sdaRel = 1'b1;
		#QTR_NS sdaRel = 1'b0;
		#QTR_NS scl = 1'b0;
		send_byte(first, ack);
		#QTR_NS sdaRel = 1'b0;
		#QTR_NS scl = 1'b1;
		#QTR_NS sdaRel = 1'b1;
		#(4*QTR_NS);
	endtask
endmodule

// [test/dlc_light_conv_bench.sv]
// Self-checking bench for the dual-channel light converter.
// Assumes short integration steps and the bus controller model.
`timescale 1ns/100ps
module dlc_light_conv_bench;
	import dlc_pkg::*;
	localparam int unsigned STEP = 4;
	logic              core_clk, srst, readLock, dataNew, intOut, intOe;
	logic              sclLine, hostRel, sdaOut, sdaOe, ackA, ackD;
	logic [DATA_W-1:0] lightCh0, lightCh1, lowLimit, highLimit, dataCh0, dataCh1;
	logic [LEN_W-1:0]  integrationLength;
	logic [3:0]        persistCount;
	logic [7:0]        lens [3] = '{8'hff, 8'hfe, 8'hfc};
	wire               sdaLine = hostRel & ~sdaOe;
	int                errors, checked, cyc, cnt;

	dlc_light_conv #(.STEP_CYC(STEP)) dlc_light_conv_i (.core_clk(core_clk), .srst(srst),
		.lightCh0(lightCh0), .lightCh1(lightCh1), .integrationLength(integrationLength),
		.lowLimit(lowLimit), .highLimit(highLimit), .persistCount(persistCount), .readLock(readLock),
		.dataCh0(dataCh0), .dataCh1(dataCh1), .dataNew(dataNew), .intOut(intOut), .intOe(intOe),
		.sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
	dlc_i2c_ctrl dlc_i2c_ctrl_i (.scl(sclLine), .sdaRel(hostRel), .sdaLine(sdaLine));

	// ---
	// Helpers
	// ---
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic give_verdict;
		$display("checked %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wait_new(output int n);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
			if (n > 3000) begin
				errors++;
				give_verdict();
			end
		end while (dataNew !== 1'b1);
	endtask

	// ---
	// Sequence
	// ---
	initial begin
		srst = 1'b1; readLock = 1'b0; persistCount = 4'h0;
		lightCh0 = 16'h0003; lightCh1 = 16'h0005; integrationLength = 8'hff;
		lowLimit = 16'h0000; highLimit = 16'hffff;
		repeat (10) @(negedge core_clk);
		srst = 1'b0;
		check("intOe", intOe, 0);
		for (int k = 0; k < 3; k++) begin
			integrationLength = lens[k];
			repeat (3) wait_new(cyc);
			check("period", cyc, (256 - lens[k]) * STEP);
			check("dataCh0", dataCh0, cyc * 3);
			check("dataCh1", dataCh1, cyc * 5);
		end
		check("intOut", intOut, 0);
		$display("test period done");
		integrationLength = 8'hfe;
		repeat (2) wait_new(cyc);
		readLock = 1'b1; lightCh0 = 16'h0007; lightCh1 = 16'h0009; cnt = 0;
		repeat (24) begin
			@(negedge core_clk);
			if (dataNew !== 1'b0) cnt++;
		end
		check("parked", cnt, 0);
		check("frozen", dataCh0, 24);
		check("frozen1", dataCh1, 40);
		readLock = 1'b0;
		wait_new(cyc);
		check("release", cyc <= 2, 1);
		check("dataCh0", dataCh0, 56);
		check("dataCh1", dataCh1, 72);
		$display("test buffer done");
		lightCh0 = 16'h0003; lightCh1 = 16'h0005; persistCount = 4'h3; highLimit = 16'h0014;
		for (int i = 1; i <= 3; i++) begin
			wait_new(cyc);
			check("intOe", intOe, i == 3);
		end
		highLimit = 16'hffff;
		repeat (2) wait_new(cyc);
		check("intOe held", intOe, 1);
		dlc_i2c_ctrl_i.write_cmd(TARGET_ADDR ^ 7'h01, CMD_INT_CLR, ackA, ackD);
		check("ack other addr", ackA, 0);
		dlc_i2c_ctrl_i.probe({TARGET_ADDR, 1'b1}, ackA);
		check("ack read", ackA, 0);
		check("sdaOe idle", sdaOe, 0);
		check("sdaOut", sdaOut, 0);
		check("intOe held", intOe, 1);
		dlc_i2c_ctrl_i.write_cmd(TARGET_ADDR, 8'h5a, ackA, ackD);
		check("ack addr", ackA, 1);
		check("ack data", ackD, 1);
		check("intOe held", intOe, 1);
		dlc_i2c_ctrl_i.write_cmd(TARGET_ADDR, CMD_INT_CLR, ackA, ackD);
		check("intOe cleared", intOe, 0);
		repeat (2) wait_new(cyc);
		check("intOe quiet", intOe, 0);
		$display("test high limit done");
		persistCount = 4'h0; lowLimit = 16'h001e;
		repeat (2) wait_new(cyc);
		check("intOe low limit", intOe, 1);
		check("intOut", intOut, 0);
		$display("test low limit done");
		give_verdict();
	end
endmodule

// [verilog/dlc_light_conv.sv]
// Dual-channel light converter: integration timing, result holding,
// limit check with persistence, level interrupt and a write-only serial target.
// Assumes light levels arrive on core_clk; serial pins are asynchronous.
`timescale 1ns/100ps

module dlc_light_conv import dlc_pkg::*; #(
	parameter int unsigned STEP_CYC = STEP_CYCLES
) (
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic [DATA_W-1:0]    lightCh0,
	input  wire logic [DATA_W-1:0]    lightCh1,
	input  wire logic [LEN_W-1:0]     integrationLength,
	input  wire logic [DATA_W-1:0]    lowLimit,
	input  wire logic [DATA_W-1:0]    highLimit,
	input  wire logic [PERSIST_W-1:0] persistCount,
	input  wire logic                 readLock,
	output logic [DATA_W-1:0]         dataCh0,
	output logic [DATA_W-1:0]         dataCh1,
	output logic                      dataNew,
	output logic                      intOut,
	output logic                      intOe,
	input  wire logic                 sclIn,
	input  wire logic                 sdaIn,
	output logic                      sdaOut,
	output logic                      sdaOe
);

	// ----------------------------------------------------------------
	// Step timer and integration
	// ----------------------------------------------------------------
	logic [STEP_CNT_W-1:0] stepCnt_q;
	logic [8:0]            stepsDone_q;
	logic [DATA_W-1:0]     acc0_q, acc1_q;
	logic [DATA_W:0]       sum0, sum1;
	logic [DATA_W-1:0]     sat0, sat1;
	logic [8:0]            stepsTarget;
	logic                  stepTick;
	logic                  convDone;

	assign stepTick    = (stepCnt_q == STEP_CNT_W'(STEP_CYC - 1));
	assign stepsTarget = STEPS_FULL - {1'b0, integrationLength};
	assign convDone    = stepTick && (stepsDone_q == (stepsTarget - 9'h001));
	assign sum0        = {1'b0, acc0_q} + {1'b0, lightCh0};
	assign sum1        = {1'b0, acc1_q} + {1'b0, lightCh1};
	assign sat0        = sum0[DATA_W] ? DATA_MAX : sum0[DATA_W-1:0];
	assign sat1        = sum1[DATA_W] ? DATA_MAX : sum1[DATA_W-1:0];

	always_ff @(posedge core_clk) begin
		if (srst || stepTick) begin
			stepCnt_q <= '0;
		end else begin
			stepCnt_q <= stepCnt_q + STEP_CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || convDone) begin
			stepsDone_q <= '0;
		end else if (stepTick) begin
			stepsDone_q <= stepsDone_q + 9'h001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || convDone) begin
			acc0_q <= DATA_RST;
			acc1_q <= DATA_RST;
		end else begin
			acc0_q <= sat0;
			acc1_q <= sat1;
		end
	end

	// ----------------------------------------------------------------
	// Result staging and holding registers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] res0_q, res1_q;
	logic              resPend_q;
	logic              xfer;

	assign xfer = resPend_q && !readLock;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			res0_q <= DATA_RST;
			res1_q <= DATA_RST;
		end else if (convDone) begin
			res0_q <= sat0;
			res1_q <= sat1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			resPend_q <= 1'b0;
		end else begin
			resPend_q <= convDone || (resPend_q && readLock);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			dataCh0 <= DATA_RST;
			dataCh1 <= DATA_RST;
			dataNew <= 1'b0;
		end else begin
			dataNew <= xfer;
			if (xfer) begin
				dataCh0 <= res0_q;
				dataCh1 <= res1_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Limit check, persistence and interrupt level
	// ----------------------------------------------------------------
	logic [PERSIST_W-1:0] persistCnt_q;
	logic [PERSIST_W:0]   persistNext;
	logic                 outOfRange;
	logic                 intSet;
	logic                 intPending_q;
	logic                 clearPulse;

	assign outOfRange  = (sat0 > highLimit) || (sat0 < lowLimit);
	assign persistNext = {1'b0, persistCnt_q} + 5'h01;
	assign intSet      = convDone && outOfRange && (persistNext >= {1'b0, persistCount});

	always_ff @(posedge core_clk) begin
		if (srst) begin
			persistCnt_q <= '0;
		end else if (convDone) begin
			if (!outOfRange) begin
				persistCnt_q <= '0;
			end else if (persistCnt_q != '1) begin
				persistCnt_q <= persistNext[PERSIST_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			intPending_q <= 1'b0;
		end else if (intSet) begin
			intPending_q <= 1'b1;
		end else if (clearPulse) begin
			intPending_q <= 1'b0;
		end
	end

	assign intOut = 1'b0;
	assign intOe  = intPending_q;

	// ----------------------------------------------------------------
	// Serial target, write only
	// ----------------------------------------------------------------
	logic           sclS1_q, sclS2_q, sclS3_q;
	logic           sdaS1_q, sdaS2_q, sdaS3_q;
	logic           sclRise, sclFall, startCond, stopCond;
	logic [7:0]     shift_q;
	logic [3:0]     bitCnt_q;
	logic           byteDone;
	logic           clear_q;
	dlc_ser_state_t serState_q, serState_d;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			{sclS1_q, sclS2_q, sclS3_q} <= 3'h7;
			{sdaS1_q, sdaS2_q, sdaS3_q} <= 3'h7;
		end else begin
			{sclS1_q, sclS2_q, sclS3_q} <= {sclIn, sclS1_q, sclS2_q};
			{sdaS1_q, sdaS2_q, sdaS3_q} <= {sdaIn, sdaS1_q, sdaS2_q};
		end
	end

	assign sclRise   = sclS2_q && !sclS3_q;
	assign sclFall   = !sclS2_q && sclS3_q;
	assign startCond = sclS2_q && sclS3_q && !sdaS2_q && sdaS3_q;
	assign stopCond  = sclS2_q && sclS3_q && sdaS2_q && !sdaS3_q;
	assign byteDone  = sclFall && (bitCnt_q == BITS_PER_BYTE);
	assign clearPulse = clear_q;

	always_comb begin
		serState_d = serState_q;
		case (serState_q)
			SER_IDLE: serState_d = SER_IDLE;
			SER_ADDR: begin
				if (byteDone) begin
					serState_d = (shift_q == {TARGET_ADDR, 1'b0}) ? SER_ACK_ADDR : SER_IDLE;
				end
			end
			SER_DATA: begin
				if (byteDone) begin
					serState_d = SER_ACK_DATA;
				end
			end
			SER_ACK_ADDR, SER_ACK_DATA: begin
				if (sclFall) begin
					serState_d = SER_DATA;
				end
			end
			default: serState_d = SER_IDLE;
		endcase
		if (startCond) begin
			serState_d = SER_ADDR;
		end else if (stopCond) begin
			serState_d = SER_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			serState_q <= SER_IDLE;
		end else begin
			serState_q <= serState_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || startCond || (serState_q != serState_d)) begin
			bitCnt_q <= '0;
		end else if (sclRise && (serState_q == SER_ADDR || serState_q == SER_DATA)) begin
			bitCnt_q <= bitCnt_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			shift_q <= '0;
		end else if (sclRise && (serState_q == SER_ADDR || serState_q == SER_DATA)) begin
			shift_q <= {shift_q[6:0], sdaS2_q};
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			clear_q <= 1'b0;
		end else begin
			clear_q <= (serState_q == SER_DATA) && byteDone && (shift_q == CMD_INT_CLR);
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe  = (serState_q == SER_ACK_ADDR) || (serState_q == SER_ACK_DATA);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_int_cause:    assert property ($rose(intOe) |-> $past(convDone) && $past(outOfRange))
		else $error("interrupt rose without out-of-range result");
	a_persist_met:  assert property (intSet && (persistCount > 4'h1) |-> persistCnt_q != '0)
		else $error("interrupt set before persistence met");
	a_int_held:     assert property (intOe && !clearPulse |=> intOe)
		else $error("interrupt dropped without clear");
	a_clear_fast:   assert property (clearPulse && !intSet |=> !intOe)
		else $error("interrupt not released after clear");
	a_pin_drive:    assert property (intOe |-> intOut == 1'b0)
		else $error("interrupt pin not driven low");
	a_restart:      assert property (convDone |=> stepsDone_q == 9'h000 && acc0_q == DATA_RST)
		else $error("integration did not restart");
	a_copy_both:    assert property (convDone |=> resPend_q && res0_q == $past(sat0) && res1_q == $past(sat1))
		else $error("results not copied together");
	a_lock_stable:  assert property (readLock |=> $stable(dataCh0) && $stable(dataCh1))
		else $error("holding changed while locked");
	a_limit_range:  assert property (intSet |=> (res0_q > $past(highLimit)) || (res0_q < $past(lowLimit)))
		else $error("interrupt set inside limits");
	a_ack_addr:     assert property ($rose(sdaOe) && serState_q == SER_ACK_ADDR |->
			$past(shift_q) == {TARGET_ADDR, 1'b0})
		else $error("acknowledged wrong address");
	a_step_len:     assert property (convDone |-> stepTick && stepsDone_q == stepsTarget - 9'h001)
		else $error("conversion length wrong");

	c_conv_done:    cover property (convDone ##[1:3] dataNew);
	c_int_raise:    cover property (intSet ##1 intOe);
	c_int_clear:    cover property (intOe ##1 clearPulse ##1 !intOe);
	c_addr_ack:     cover property (serState_q == SER_ACK_ADDR);

endmodule

// [verilog/dlc_pkg.sv]
// Constants for the dual-channel light converter.
// Assumes a single 100 MHz core clock and a synchronous active-high reset.
package dlc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned STEP_TIME_US  = 2700;
	localparam int unsigned STEP_CYCLES   = (STEP_TIME_US * 1000) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Widths and field layout
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W       = 16;
	localparam int unsigned STEP_CNT_W   = 19;
	localparam int unsigned LEN_W        = 8;
	localparam int unsigned PERSIST_W    = 4;
	localparam logic [8:0]  STEPS_FULL   = 9'h100;
	localparam logic [15:0] DATA_MAX     = 16'hffff;
	localparam logic [15:0] DATA_RST     = 16'h0000;

	// ----------------------------------------------------------------
	// Serial target
	// ----------------------------------------------------------------
	localparam logic [6:0]  TARGET_ADDR  = 7'h2a;
	localparam logic [7:0]  CMD_INT_CLR  = 8'he0;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		SER_IDLE,
		SER_ADDR,
		SER_DATA,
		SER_ACK_ADDR,
		SER_ACK_DATA
	} dlc_ser_state_t;

endpackage
